// [rtl/acc_pkg.sv]
// package: register map, field positions and encodings of the comparator control block
package acc_pkg;
   // ********************************
   // register offsets
   // ********************************
   localparam logic [7:0] ADDR_CONV_CTRL_B = 8'h7B;
   localparam logic [7:0] ADDR_CMP_CTRL_STATUS = 8'h50;
   localparam logic [7:0] ADDR_CONV_CTRL_A = 8'h7A;
   localparam logic [7:0] ADDR_CONV_MUX = 8'h7C;
   localparam logic [7:0] ADDR_EVT_STATUS = 8'hE0;
   localparam logic [7:0] ADDR_EVT_MASK = 8'hE1;
   // ********************************
   // field positions
   // ********************************
   localparam int BIT_NEG_MUX_ENABLE = 6;
   localparam int BIT_CMP_DISABLE = 7;
   localparam int BIT_REF_SELECT = 6;
   localparam int BIT_CMP_RESULT = 5;
   localparam int BIT_CMP_IRQ_FLAG = 4;
   localparam int BIT_CMP_IRQ_ENABLE = 3;
   localparam int BIT_CAPTURE_ROUTE = 2;
   localparam int BIT_CONVERTER_ENABLE = 7;
   localparam int BIT_EVT_CMP = 0;
   localparam int BIT_EVT_RESULT_CHG = 1;
   // ********************************
   // reset values
   // ********************************
   localparam logic [7:0] RST_CONV_CTRL_B = 8'h00;
   localparam logic [7:0] RST_CMP_CTRL = 8'h00;
   localparam logic [7:0] RST_CONV_CTRL_A = 8'h00;
   localparam logic [7:0] RST_CONV_MUX = 8'h00;
   localparam logic [1:0] RST_EVT = 2'h0;
   // ********************************
   // interrupt mode encodings
   // ********************************
   localparam logic [1:0] MODE_TOGGLE = 2'h0;
   localparam logic [1:0] MODE_RESERVED = 2'h1;
   localparam logic [1:0] MODE_FALL = 2'h2;
   localparam logic [1:0] MODE_RISE = 2'h3;
   // negative input route codes
   localparam logic [3:0] NEG_ROUTE_PIN = 4'h8;
   // synchroniser depth
   localparam int SYNC_STAGES = 2;
endpackage

// [rtl/acc_sync.sv]
// two-flop synchroniser for the asynchronous comparator decision
`timescale 1ns/100ps
`default_nettype none
module acc_sync
   import acc_pkg::*;
(
   input wire logic core_clk_i,  // system clock
   input wire logic reset_n_i,   // synchronous reset, active low
   input wire logic async_i,     // raw level from the analog side
   output logic sync_o           // level safe for core logic
);
   logic meta_ff;
   logic sync_ff;

   // first stage is read by the second stage only
   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
      begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
      end
      else
      begin
         meta_ff <= async_i;
         sync_ff <= meta_ff;
      end
   end

   assign sync_o = sync_ff;
endmodule
`default_nettype wire

// [rtl/acc_top.sv]
// comparator control logic: input select, result sync, event detect, capture route, registers
`timescale 1ns/100ps
`default_nettype none
module acc_top
   import acc_pkg::*;
(
   input wire logic core_clk_i,         // system clock, 50 MHz
   input wire logic reset_n_i,          // synchronous reset, active low
   input wire logic [7:0] addr_i,       // register address
   input wire logic [7:0] wdata_i,      // write data
   input wire logic wr_i,               // write strobe
   input wire logic rd_i,               // read strobe
   output logic [7:0] rdata_o,          // read data, cycle after the strobe
   input wire logic cmp_raw_i,          // analog comparator decision, asynchronous
   input wire logic global_irq_en_i,    // processor global interrupt enable
   input wire logic vector_ack_i,       // processor enters the comparator vector
   output logic cmp_irq_o,              // comparator interrupt request
   output logic evt_irq_o,              // summary interrupt from event status
   output logic ref_select_o,           // 1: internal reference on positive input
   output logic cmp_power_down_o,       // 1: comparator unpowered
   output logic [3:0] neg_route_o,      // 0..7 converter channel, 8 negative pin
   output logic converter_enable_o,     // converter on
   output logic [2:0] trigger_source_sel_o, // converter trigger source
   output logic capture_route_enable_o, // result routed to timer capture
   output logic capture_input_o         // comparator result for the timer front end
);
   // ********************************
   // register state
   // ********************************
   logic neg_mux_enable_ff;
   logic [2:0] trigger_source_sel_ff;
   logic cmp_disable_ff;
   logic ref_select_ff;
   logic cmp_irq_flag_ff;
   logic cmp_irq_enable_ff;
   logic capture_route_enable_ff;
   logic [1:0] irq_mode_ff;
   logic converter_enable_ff;
   logic [6:0] conv_ctrl_a_rest_ff;
   logic [2:0] channel_select_ff;
   logic [4:0] conv_mux_rest_ff;
   logic [1:0] evt_status_ff;
   logic [1:0] evt_mask_ff;
   logic [7:0] rdata_ff;
   logic cmp_irq_ff;
   logic evt_irq_ff;
   logic [3:0] neg_route_ff;
   logic capture_input_ff;
   logic cmp_result;
   logic cmp_prev_ff;
   logic cmp_event;
   logic result_chg;
   logic [7:0] nxt_rdata;
   logic wr_ctrl;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   assign wr_ctrl = wr_i && hit(addr_i, ADDR_CMP_CTRL_STATUS);

   // ********************************
   // result synchroniser
   // ********************************
   // the analog decision is already the comparison, only the timing needs fixing
   acc_sync u_sync (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .async_i(cmp_raw_i),
      .sync_o(cmp_result)
   );

   // previous sample for edge detection
   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
         cmp_prev_ff <= 1'b0;
      else
         cmp_prev_ff <= cmp_result;
   end

   // event decode; reserved mode never fires so a stray code cannot interrupt
   always_comb
   begin
      result_chg = cmp_result ^ cmp_prev_ff;
      unique case (irq_mode_ff)
         MODE_TOGGLE: cmp_event = result_chg;
         MODE_RESERVED: cmp_event = 1'b0;
         MODE_FALL: cmp_event = cmp_prev_ff && !cmp_result;
         MODE_RISE: cmp_event = !cmp_prev_ff && cmp_result;
      endcase
   end

   // ********************************
   // control registers
   // ********************************
   // converter control B: mux enable and trigger select
   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
      begin
         neg_mux_enable_ff <= RST_CONV_CTRL_B[BIT_NEG_MUX_ENABLE];
         trigger_source_sel_ff <= RST_CONV_CTRL_B[2:0];
      end
      else if (wr_i && hit(addr_i, ADDR_CONV_CTRL_B))
      begin
         neg_mux_enable_ff <= wdata_i[BIT_NEG_MUX_ENABLE];
         trigger_source_sel_ff <= wdata_i[2:0];
      end
   end

   // comparator control; disable written any time, no gating on state
   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
      begin
         cmp_disable_ff <= RST_CMP_CTRL[BIT_CMP_DISABLE];
         ref_select_ff <= RST_CMP_CTRL[BIT_REF_SELECT];
         cmp_irq_enable_ff <= RST_CMP_CTRL[BIT_CMP_IRQ_ENABLE];
         capture_route_enable_ff <= RST_CMP_CTRL[BIT_CAPTURE_ROUTE];
         irq_mode_ff <= RST_CMP_CTRL[1:0];
      end
      else if (wr_ctrl)
      begin
         cmp_disable_ff <= wdata_i[BIT_CMP_DISABLE];
         ref_select_ff <= wdata_i[BIT_REF_SELECT];
         cmp_irq_enable_ff <= wdata_i[BIT_CMP_IRQ_ENABLE];
         capture_route_enable_ff <= wdata_i[BIT_CAPTURE_ROUTE];
         irq_mode_ff <= wdata_i[1:0];
      end
   end

   // interrupt flag: a same-cycle event beats both clear paths
   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
         cmp_irq_flag_ff <= RST_CMP_CTRL[BIT_CMP_IRQ_FLAG];
      else if (cmp_event)
         cmp_irq_flag_ff <= 1'b1;
      else if (vector_ack_i)
         cmp_irq_flag_ff <= 1'b0;
      else if (wr_ctrl && wdata_i[BIT_CMP_IRQ_FLAG])
         cmp_irq_flag_ff <= 1'b0;
   end

   // converter control A and mux; only the enable and channel act here
   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
      begin
         converter_enable_ff <= RST_CONV_CTRL_A[BIT_CONVERTER_ENABLE];
         conv_ctrl_a_rest_ff <= RST_CONV_CTRL_A[6:0];
         channel_select_ff <= RST_CONV_MUX[2:0];
         conv_mux_rest_ff <= RST_CONV_MUX[7:3];
      end
      else
      begin
         if (wr_i && hit(addr_i, ADDR_CONV_CTRL_A))
         begin
            converter_enable_ff <= wdata_i[BIT_CONVERTER_ENABLE];
            conv_ctrl_a_rest_ff <= wdata_i[6:0];
         end
         if (wr_i && hit(addr_i, ADDR_CONV_MUX))
         begin
            channel_select_ff <= wdata_i[2:0];
            conv_mux_rest_ff <= wdata_i[7:3];
         end
      end
   end

   // ********************************
   // input routing and capture
   // ********************************
   // power reduction is software's job; the channel route is taken only while the mux enable is set and the converter is off, else the pin
   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
         neg_route_ff <= NEG_ROUTE_PIN;
      else if (neg_mux_enable_ff && !converter_enable_ff)
         neg_route_ff <= {1'b0, channel_select_ff};
      else
         neg_route_ff <= NEG_ROUTE_PIN;
   end

   // capture feed held low when not routed, so the timer sees no edges
   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
         capture_input_ff <= 1'b0;
      else
         capture_input_ff <= capture_route_enable_ff && cmp_result;
   end

   // ********************************
   // interrupts
   // ********************************
   // software must drop the enable around mode or disable changes
   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
         cmp_irq_ff <= 1'b0;
      else
         cmp_irq_ff <= cmp_irq_flag_ff && cmp_irq_enable_ff && global_irq_en_i;
   end

   // event status: sticky, read clears, set wins over the read clear
   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
         evt_status_ff <= RST_EVT;
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            if ((i == BIT_EVT_CMP && cmp_event) || (i == BIT_EVT_RESULT_CHG && result_chg))
               evt_status_ff[i] <= 1'b1;
            else if (rd_i && hit(addr_i, ADDR_EVT_STATUS))
               evt_status_ff[i] <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
         evt_mask_ff <= RST_EVT;
      else if (wr_i && hit(addr_i, ADDR_EVT_MASK))
         evt_mask_ff <= wdata_i[1:0];
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
         evt_irq_ff <= 1'b0;
      else
         evt_irq_ff <= |(evt_status_ff & evt_mask_ff);
   end

   // ********************************
   // read path
   // ********************************
   // unmapped addresses read zero
   always_comb
   begin
      nxt_rdata = 8'h00;
      unique case (1'b1)
         hit(addr_i, ADDR_CONV_CTRL_B):
            nxt_rdata = {1'b0, neg_mux_enable_ff, 3'h0, trigger_source_sel_ff};
         hit(addr_i, ADDR_CMP_CTRL_STATUS):
            nxt_rdata = {cmp_disable_ff, ref_select_ff, cmp_result, cmp_irq_flag_ff,
                         cmp_irq_enable_ff, capture_route_enable_ff, irq_mode_ff};
         hit(addr_i, ADDR_CONV_CTRL_A):
            nxt_rdata = {converter_enable_ff, conv_ctrl_a_rest_ff};
         hit(addr_i, ADDR_CONV_MUX):
            nxt_rdata = {conv_mux_rest_ff, channel_select_ff};
         hit(addr_i, ADDR_EVT_STATUS):
            nxt_rdata = {6'h00, evt_status_ff};
         hit(addr_i, ADDR_EVT_MASK):
            nxt_rdata = {6'h00, evt_mask_ff};
         default:
            nxt_rdata = 8'h00;
      endcase
   end

   // data stand only in the cycle after the strobe
   always_ff @(posedge core_clk_i)
   begin
      if (!reset_n_i)
         rdata_ff <= 8'h00;
      else if (rd_i)
         rdata_ff <= nxt_rdata;
      else
         rdata_ff <= 8'h00;
   end

   assign rdata_o = rdata_ff;
   assign cmp_irq_o = cmp_irq_ff;
   assign evt_irq_o = evt_irq_ff;
   assign ref_select_o = ref_select_ff;
   assign cmp_power_down_o = cmp_disable_ff;
   assign neg_route_o = neg_route_ff;
   assign converter_enable_o = converter_enable_ff;
   assign trigger_source_sel_o = trigger_source_sel_ff;
   assign capture_route_enable_o = capture_route_enable_ff;
   assign capture_input_o = capture_input_ff;
endmodule
`default_nettype wire

// [bench/acc_checker.sv]
// checker: port-level properties of the comparator control block
`timescale 1ns/100ps
`default_nettype none
module acc_checker
   import acc_pkg::*;
(
   input wire logic core_clk_i,             // system clock
   input wire logic reset_n_i,              // synchronous reset, active low
   input wire logic [7:0] addr_i,           // register address
   input wire logic [7:0] wdata_i,          // write data
   input wire logic wr_i,                   // write strobe
   input wire logic rd_i,                   // read strobe
   input wire logic [7:0] rdata_o,          // read data
   input wire logic cmp_raw_i,              // raw comparator decision
   input wire logic global_irq_en_i,        // global interrupt enable
   input wire logic vector_ack_i,           // vector entry pulse
   input wire logic cmp_irq_o,              // comparator interrupt request
   input wire logic ref_select_o,           // positive input choice
   input wire logic cmp_power_down_o,       // comparator unpowered
   input wire logic [3:0] neg_route_o,      // negative input route
   input wire logic converter_enable_o,     // converter on
   input wire logic capture_route_enable_o, // capture route on
   input wire logic capture_input_o         // result to the capture front end
);
   // ********************************
   // properties
   // ********************************
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!reset_n_i);
   wire logic ctrl_wr = wr_i && (addr_i == ADDR_CMP_CTRL_STATUS);
   a_ctrl_write_fields: assert property (ctrl_wr |=> ref_select_o == $past(wdata_i[BIT_REF_SELECT]) &&
      cmp_power_down_o == $past(wdata_i[BIT_CMP_DISABLE]) && capture_route_enable_o == $past(wdata_i[2]))
      else $error("control write fields not taken");
   a_conv_enable_write: assert property (wr_i && addr_i == ADDR_CONV_CTRL_A |=>
      converter_enable_o == $past(wdata_i[BIT_CONVERTER_ENABLE])) else $error("converter enable not taken");
   a_route_pin_conv: assert property (converter_enable_o && $past(converter_enable_o) |->
      neg_route_o == NEG_ROUTE_PIN) else $error("negative route not pin while converter on");
   a_result_readback: assert property ($stable(cmp_raw_i) [*4] ##0 rd_i && addr_i == ADDR_CMP_CTRL_STATUS
      |=> rdata_o[BIT_CMP_RESULT] == $past(cmp_raw_i)) else $error("result bit wrong");
   a_cap_follow_hi: assert property ((capture_route_enable_o && cmp_raw_i) [*3] |=> capture_input_o)
      else $error("capture input missed high result");
   a_cap_follow_lo: assert property ((!cmp_raw_i) [*3] |=> !capture_input_o)
      else $error("capture input high on low result");
   a_cap_off: assert property (!capture_route_enable_o && !$past(capture_route_enable_o) |-> !capture_input_o)
      else $error("capture input while route off");
   a_irq_global_gate: assert property (!global_irq_en_i |=> !cmp_irq_o)
      else $error("request without global enable");
   a_flag_clear_drops: assert property ($stable(cmp_raw_i) [*4] ##0 (vector_ack_i ||
      (ctrl_wr && wdata_i[BIT_CMP_IRQ_FLAG])) |=> ##1 !cmp_irq_o) else $error("request after flag clear");
   // coverage of the main scenarios
   c_irq_seen: cover property (cmp_irq_o);
   c_ack_seen: cover property (vector_ack_i && cmp_irq_o);
   c_evt_read: cover property (rd_i && addr_i == ADDR_EVT_STATUS);
endmodule
bind acc_top acc_checker u_chk (.core_clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .cmp_raw_i,
   .global_irq_en_i, .vector_ack_i, .cmp_irq_o, .ref_select_o, .cmp_power_down_o, .neg_route_o,
   .converter_enable_o, .capture_route_enable_o, .capture_input_o);
`default_nettype wire

// [bench/acc_top_test.sv]
// testbench: self-checking scenarios for the comparator control block
`timescale 1ns/100ps
`default_nettype none
module acc_top_test
   import acc_pkg::*;
;
   logic core_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic cmp_raw_i = 1'b0;
   logic global_irq_en_i = 1'b0;
   logic vector_ack_i = 1'b0;
   logic [7:0] rdata_o;
   logic cmp_irq_o, evt_irq_o, ref_select_o, cmp_power_down_o, converter_enable_o;
   logic capture_route_enable_o, capture_input_o;
   logic [3:0] neg_route_o;
   logic [2:0] trigger_source_sel_o;
   int bad_count = 0;
   int checks_done = 0;
   int i;
   // ********************************
   // clock, design, helpers
   // ********************************
   always #10 core_clk_i = ~core_clk_i;
   acc_top DUT (.core_clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .cmp_raw_i, .global_irq_en_i,
      .vector_ack_i, .cmp_irq_o, .evt_irq_o, .ref_select_o, .cmp_power_down_o, .neg_route_o, .converter_enable_o,
      .trigger_source_sel_o, .capture_route_enable_o, .capture_input_o);
   task chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one-cycle strobes, launched just after an edge
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge core_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge core_clk_i);
      rd_i <= 1'b0;
      #1 chk(rdata_o & m, e);
   endtask
   task tick(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask
   // raw decision change; five edges cover sync plus flag plus request
   task raw(input logic v);
      @(posedge core_clk_i);
      cmp_raw_i <= v;
      tick(5);
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // ********************************
   // scenarios
   // ********************************
   task t_reset;
      #1 chk(8'(neg_route_o), 8'h08);
      chk(8'({cmp_irq_o, evt_irq_o, ref_select_o, cmp_power_down_o, capture_route_enable_o, capture_input_o}), 8'h00);
      rd(ADDR_CMP_CTRL_STATUS, 8'hFF, RST_CMP_CTRL);
      rd(ADDR_CONV_CTRL_B, 8'hFF, RST_CONV_CTRL_B);
      rd(ADDR_CONV_CTRL_A, 8'hFF, RST_CONV_CTRL_A);
      rd(8'h33, 8'hFF, 8'h00);
      $display("test reset done");
   endtask
   task t_route;
      wr(ADDR_CONV_CTRL_B, 8'hFF);
      rd(ADDR_CONV_CTRL_B, 8'hFF, 8'h47);
      tick(1);
      chk(rdata_o, 8'h00);
      chk(8'(trigger_source_sel_o), 8'h07);
      for (i = 0; i < 8; i++)
      begin
         wr(ADDR_CONV_MUX, 8'(i));
         tick(1);
         chk(8'(neg_route_o), 8'(i));
      end
      wr(ADDR_CONV_CTRL_A, 8'h80);
      tick(1);
      chk(8'(neg_route_o), 8'h08);
      chk(8'(converter_enable_o), 8'h01);
      wr(ADDR_CONV_CTRL_A, 8'h00);
      wr(ADDR_CONV_CTRL_B, 8'h00);
      tick(1);
      chk(8'(neg_route_o), 8'h08);
      $display("test route done");
   endtask
   task t_ctrl;
      wr(ADDR_CMP_CTRL_STATUS, 8'hC4);
      #1 chk(8'({ref_select_o, cmp_power_down_o, capture_route_enable_o}), 8'h07);
      raw(1'b1);
      chk(8'(capture_input_o), 8'h01);
      rd(ADDR_CMP_CTRL_STATUS, 8'h20, 8'h20);
      wr(ADDR_CMP_CTRL_STATUS, 8'h10);
      tick(2);
      chk(8'(capture_input_o), 8'h00);
      raw(1'b0);
      $display("test control done");
   endtask
   // every mode, rising then falling result, irq enable kept clear
   task t_modes;
      for (i = 0; i < 4; i++)
      begin
         wr(ADDR_CMP_CTRL_STATUS, 8'h10 | 8'(i));
         raw(1'b1);
         rd(ADDR_CMP_CTRL_STATUS, 8'h30, (i == 0 || i == 3) ? 8'h30 : 8'h20);
         wr(ADDR_CMP_CTRL_STATUS, 8'h10 | 8'(i));
         raw(1'b0);
         rd(ADDR_CMP_CTRL_STATUS, 8'h30, (i == 0 || i == 2) ? 8'h10 : 8'h00);
         wr(ADDR_CMP_CTRL_STATUS, 8'h10 | 8'(i));
      end
      $display("test modes done");
   endtask
   task t_irq;
      global_irq_en_i <= 1'b1;
      wr(ADDR_CMP_CTRL_STATUS, 8'h0B);
      raw(1'b1);
      chk(8'(cmp_irq_o), 8'h01);
      @(posedge core_clk_i);
      global_irq_en_i <= 1'b0;
      tick(2);
      chk(8'(cmp_irq_o), 8'h00);
      @(posedge core_clk_i);
      global_irq_en_i <= 1'b1;
      tick(2);
      chk(8'(cmp_irq_o), 8'h01);
      @(posedge core_clk_i);
      vector_ack_i <= 1'b1;
      @(posedge core_clk_i);
      vector_ack_i <= 1'b0;
      tick(2);
      chk(8'(cmp_irq_o), 8'h00);
      raw(1'b0);
      raw(1'b1);
      wr(ADDR_CMP_CTRL_STATUS, 8'h0B);
      tick(2);
      chk(8'(cmp_irq_o), 8'h01);
      wr(ADDR_CMP_CTRL_STATUS, 8'h1B);
      tick(2);
      chk(8'(cmp_irq_o), 8'h00);
      $display("test interrupt done");
   endtask
   // stale status from earlier tests is read away first, so the summary must rise on its own
   task t_evt;
      rd(ADDR_EVT_STATUS, 8'h03, 8'h03);
      wr(ADDR_EVT_MASK, 8'h02);
      tick(2);
      chk(8'(evt_irq_o), 8'h00);
      raw(1'b0);
      chk(8'(evt_irq_o), 8'h01);
      rd(ADDR_EVT_STATUS, 8'h03, 8'h02);
      tick(2);
      chk(8'(evt_irq_o), 8'h00);
      wr(ADDR_EVT_MASK, 8'h00);
      raw(1'b1);
      chk(8'(evt_irq_o), 8'h00);
      $display("test event status done");
   endtask
   // watchdog: the whole run needs well under a thousand cycles
   initial
   begin
      repeat (3000) @(posedge core_clk_i);
      bad_count++;
      wrap_up;
   end
   initial
   begin
      repeat (2) @(posedge core_clk_i);
      reset_n_i <= 1'b1;
      t_reset;
      t_route;
      t_ctrl;
      t_modes;
      t_irq;
      t_evt;
      wrap_up;
   end
endmodule
`default_nettype wire
